// ===== hw/rps_pkg.sv
// Shared constants and types for the ranging power state controller.
// Assumes a single 250 MHz core clock and a two-wire serial host.
package rps_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int EMIT_PERIOD_NS = 100;
    localparam int EMIT_CYCLES = (EMIT_PERIOD_NS * 1000) / CLK_PERIOD_PS;
    localparam int FRAME_PULSES = 16;

    // ****************************************************************
    // Serial slave addressing
    // ****************************************************************
    localparam logic [6:0] DEV_ADDR7 = 7'h29;
    localparam logic [15:0] CMD_IDX = 16'h7FF0;
    localparam logic [15:0] STATUS_IDX = 16'h7FF1;
    localparam logic [15:0] IDX_RESET = 16'h0000;

    // ****************************************************************
    // Power commands written to the command index
    // ****************************************************************
    localparam logic [7:0] CMD_SLEEP = 8'h01;
    localparam logic [7:0] CMD_WAKE = 8'h02;
    localparam logic [7:0] CMD_START = 8'h03;
    localparam logic [7:0] CMD_STOP = 8'h04;

    // ****************************************************************
    // State encodings
    // ****************************************************************
    typedef enum logic [1:0] {
        P_AWAKE = 2'b00,
        P_SLEEP = 2'b01,
        P_RANGING = 2'b10
    } rps_power_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_IDX_HI = 3'b010,
        S_IDX_LO = 3'b011,
        S_WRITE = 3'b100,
        S_ACK = 3'b101,
        S_READ = 3'b110,
        S_HOST_ACK = 3'b111
    } rps_i2c_state_t;

endpackage

// ===== hw/rps_mem_if.sv
// Carrier between the controller and its retained register store.
// Assumes both ends sit on the same core clock.
`timescale 1ns/100ps
interface rps_mem_if #(parameter int AW = 8);
    logic wr_en;
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output wr_en, output addr, output wdata, input rdata);
    modport store (input wr_en, input addr, input wdata, output rdata);
endinterface

// ===== hw/rps_store.sv
// Retained byte store behind the serial register index.
// Assumes the controller holds the address steady while it reads.
`timescale 1ns/100ps
module rps_store #(
    parameter int AW = 8
) (
    // Clock
    input wire logic clk,
    // Access port
    rps_mem_if.store mem
);
    logic [7:0] cells [0:(1<<AW)-1];

    // No reset: contents survive sleep and bus resets alike
    always_ff @(posedge clk) begin
        if (mem.wr_en) begin
            cells[mem.addr] <= mem.wdata;
        end
        mem.rdata <= cells[mem.addr];
    end
endmodule

// ===== hw/rps_ctrl.sv
// Power state control and two-wire serial slave of the ranging sensor.
// Assumes SCL, SDA, bus reset and comms enable arrive asynchronously
// from pins; pad logic resolves the open-drain wires from the enables.
`timescale 1ns/100ps

// Overview of operation
// - Bus reset pin pulse reinitialises serial slave
// - Bus reset leaves power state and store
// - Sleeping with comms enable low ignores bus
// - Sleeping with comms enable high answers bus
// - Event pin only pulls low, else floats
// - Spare pin defaults open-drain, never high
// - Sleep keeps store and registers intact
// - Sleep wakes quickly without reloading contents
// - Power up awake; ranging starts only awake
// - Emitter pulses ranging only, off idle
// - Answer address 0x52/0x53 with low ack
// - Write: 16-bit index, then acked data
// - Index advances by one per byte
module rps_ctrl
    import rps_pkg::*;
#(
    parameter int AW = 8
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Control pins
    input wire logic I2C_RESET,
    input wire logic COMMS_ENABLE_LOW_POWER,
    // Serial bus
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // Event and spare pins
    input wire logic INT_IN,
    output logic INT_OUT,
    output logic INT_OE,
    input wire logic SPARE_GPIO_IN,
    output logic SPARE_GPIO_OUT,
    output logic SPARE_GPIO_OE,
    // Core status
    output logic EMITTER_PULSE,
    output logic [1:0] POWER_STATE
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [2:0] scl_q, sda_q, rst_q, en_q;
    logic scl_s, sda_s, rst_s, en_s, scl_d, sda_d, rst_d;

    // Three flops; a level counts once the last two agree
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            {scl_q, sda_q, rst_q, en_q} <= 12'hFC7;
        end else begin
            {scl_q, sda_q} <= {scl_q[1:0], SCL, sda_q[1:0], SDA_IN};
            {rst_q, en_q} <= {rst_q[1:0], I2C_RESET, en_q[1:0], COMMS_ENABLE_LOW_POWER};
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            {scl_s, sda_s, rst_s, en_s} <= 4'hD;
            {scl_d, sda_d, rst_d} <= 3'h6;
        end else begin
            if (scl_q[1] == scl_q[2]) scl_s <= scl_q[2];
            if (sda_q[1] == sda_q[2]) sda_s <= sda_q[2];
            if (rst_q[1] == rst_q[2]) rst_s <= rst_q[2];
            if (en_q[1] == en_q[2]) en_s <= en_q[2];
            {scl_d, sda_d, rst_d} <= {scl_s, sda_s, rst_s};
        end
    end

    // ****************************************************************
    // Bus events and gating
    // ****************************************************************
    rps_power_t pstate;
    logic bus_off, scl_rise, scl_fall, start_c, stop_c, slave_clr;
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_c = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
    // Sleep with comms disabled: traffic ignored; enabled: answered
    assign bus_off = (pstate == P_SLEEP) & ~en_s;
    // Held or falling bus reset returns only the slave to idle
    assign slave_clr = rst_s | rst_d | bus_off;

    // ****************************************************************
    // Serial slave
    // ****************************************************************
    rps_mem_if #(.AW(AW)) mem ();
    rps_i2c_state_t st, after_ack;
    logic [7:0] shreg, tx, cmd_byte, rd_byte;
    logic [3:0] bitcnt;
    logic [15:0] idx;
    logic rd_mode, sda_oe, cmd_valid, status_rd, data_ready, byte_in, addr_hit, wr_data;
    assign byte_in = (bitcnt == 4'h8);
    assign addr_hit = (shreg[7:1] == DEV_ADDR7);
    assign wr_data = scl_fall & byte_in & (st == S_WRITE);
    assign rd_byte = (idx == STATUS_IDX) ? {5'h00, data_ready, pstate} : mem.rdata;
    assign mem.addr = idx[AW-1:0];
    assign mem.wdata = shreg;
    assign mem.wr_en = wr_data & ~slave_clr;
    // Bit engine: sample on SCL rise, drive on SCL fall
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st <= S_IDLE;
            after_ack <= S_IDLE;
            {shreg, tx, bitcnt} <= 20'h00000;
            idx <= IDX_RESET;
            {rd_mode, sda_oe} <= 2'h0;
        end else if (slave_clr || stop_c) begin
            st <= S_IDLE;
            sda_oe <= 1'b0;
        end else if (start_c) begin
            st <= S_ADDR;
            bitcnt <= 4'h0;
            sda_oe <= 1'b0;
        end else if (scl_rise && st inside {S_ADDR, S_IDX_HI, S_IDX_LO, S_WRITE}) begin
            shreg <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
        end else if (scl_rise && st == S_HOST_ACK) begin
            if (sda_s) st <= S_IDLE; // Host nack ends the read
            idx <= idx + 16'h0001;
        end else if (scl_fall) begin
            unique case (st)
                S_ADDR: if (byte_in) begin
                    if (addr_hit) begin
                        sda_oe <= 1'b1;
                        rd_mode <= shreg[0];
                        after_ack <= shreg[0] ? S_READ : S_IDX_HI;
                        st <= S_ACK;
                    end else begin
                        st <= S_IDLE;
                    end
                end
                S_IDX_HI: if (byte_in) begin
                    idx[15:8] <= shreg;
                    sda_oe <= 1'b1;
                    after_ack <= S_IDX_LO;
                    st <= S_ACK;
                end
                S_IDX_LO: if (byte_in) begin
                    idx[7:0] <= shreg;
                    sda_oe <= 1'b1;
                    after_ack <= S_WRITE;
                    st <= S_ACK;
                end
                S_WRITE: if (byte_in) begin
                    idx <= idx + 16'h0001;
                    sda_oe <= 1'b1;
                    after_ack <= S_WRITE;
                    st <= S_ACK;
                end
                S_ACK, S_HOST_ACK: begin
                    bitcnt <= 4'h0;
                    st <= (st == S_HOST_ACK) ? S_READ : after_ack;
                    sda_oe <= 1'b0;
                    if (rd_mode) begin
                        tx <= rd_byte;
                        sda_oe <= ~rd_byte[7];
                        bitcnt <= 4'h1;
                        st <= S_READ;
                    end
                end
                S_READ: begin
                    if (byte_in) begin
                        sda_oe <= 1'b0;
                        st <= S_HOST_ACK;
                    end else begin
                        sda_oe <= ~tx[6];
                        tx <= {tx[6:0], 1'b0};
                        bitcnt <= bitcnt + 4'h1;
                    end
                end
                S_IDLE: sda_oe <= 1'b0;
            endcase
        end
    end

    // Command byte captured from writes to the command index
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            {cmd_valid, cmd_byte, status_rd} <= 10'h000;
        end else begin
            cmd_valid <= mem.wr_en & (idx == CMD_IDX);
            cmd_byte <= shreg;
            status_rd <= scl_fall & ~slave_clr & (st == S_ACK || st == S_HOST_ACK)
                & rd_mode & (idx == STATUS_IDX);
        end
    end
    rps_store #(.AW(AW)) i_rps_store (.clk(CORE_CLK), .mem(mem));
    // ****************************************************************
    // Power states and emitter
    // ****************************************************************
    logic [15:0] emit_cnt;
    logic [7:0] pulse_cnt;
    logic emit_tick, emitter, stop_pend;
    assign emit_tick = (emit_cnt == 16'(EMIT_CYCLES - 1));
    // Power-up state is awake; sleep only by command
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pstate <= P_AWAKE;
            stop_pend <= 1'b0;
        end else begin
            if (cmd_valid) begin
                unique case (pstate)
                    P_AWAKE: begin
                        if (cmd_byte == CMD_SLEEP) pstate <= P_SLEEP;
                        if (cmd_byte == CMD_START) pstate <= P_RANGING;
                    end
                    P_SLEEP: if (cmd_byte == CMD_WAKE) pstate <= P_AWAKE;
                    P_RANGING: if (cmd_byte == CMD_STOP) stop_pend <= 1'b1;
                    default: pstate <= P_AWAKE;
                endcase
            end
            // Stop takes effect at the end of the current pulse period
            if (stop_pend && emit_tick) begin
                pstate <= P_AWAKE;
                stop_pend <= 1'b0;
            end
        end
    end

    // Divider counts only while ranging so idle states draw nothing
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            {emit_cnt, pulse_cnt} <= 24'h000000;
            {emitter, data_ready} <= 2'h0;
        end else begin
            emit_cnt <= (pstate != P_RANGING || emit_tick) ? 16'h0000 : emit_cnt + 16'h0001;
            if (pstate != P_RANGING || (stop_pend && emit_tick)) begin
                emitter <= 1'b0;
            end else if (emit_tick) begin
                emitter <= ~emitter;
                pulse_cnt <= pulse_cnt + 8'h01;
            end
            // Frame event set wins over the clearing status read
            if (emit_tick && pstate == P_RANGING && pulse_cnt == 8'(FRAME_PULSES - 1)) begin
                data_ready <= 1'b1;
                pulse_cnt <= 8'h00;
            end else if (status_rd) begin
                data_ready <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Output registers
    // ****************************************************************
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            {SDA_OUT, SDA_OE, INT_OUT, INT_OE} <= 4'h0;
            {SPARE_GPIO_OUT, SPARE_GPIO_OE, EMITTER_PULSE} <= 3'h0; // Spare floats
            POWER_STATE <= P_AWAKE;
        end else begin
            SDA_OE <= sda_oe;
            INT_OE <= data_ready; // Pull low only; never drive high
            EMITTER_PULSE <= emitter;
            POWER_STATE <= pstate;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_rst_pulse;
        !rst_s ##1 rst_s;
    endsequence

    a_emit_idle_off: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (pstate != P_RANGING) |=> !EMITTER_PULSE) else $error("emitter on while idle");
    a_int_open_drain: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        INT_OUT == 1'b0) else $error("event pin driven high");
    a_spare_tristate: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        !SPARE_GPIO_OE && !SPARE_GPIO_OUT) else $error("spare pin driven");
    a_sleep_ignores: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        bus_off |=> st == S_IDLE ##1 !SDA_OE) else $error("bus answered while disabled");
    a_bus_rst_idle: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        s_rst_pulse |=> (st == S_IDLE) && !sda_oe) else $error("slave not reset");
    a_bus_rst_keep: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (rst_s && !cmd_valid && !emit_tick) |=> $stable(pstate)) else $error("core disturbed");
    a_start_awake: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (cmd_valid && pstate == P_SLEEP) |=> pstate != P_RANGING) else $error("ranged from sleep");
    a_idx_step: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        mem.wr_en |=> idx == 16'($past(idx) + 16'h0001)) else $error("index did not advance");
    a_addr_ack: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (scl_fall && st == S_ADDR && byte_in && addr_hit && !slave_clr && !stop_c && !start_c)
        |=> sda_oe ##1 SDA_OE) else $error("address not acknowledged");
    a_stop_return: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (stop_pend && emit_tick) |=> (pstate == P_AWAKE) && !emitter) else $error("stop ignored");
    a_sleep_by_cmd: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        !cmd_valid |=> (pstate == P_SLEEP) == ($past(pstate) == P_SLEEP))
        else $error("sleep changed without command");
endmodule

// ===== tb/rps_host_model.sv
// Host side of the two-wire bus: a bus master that drives SCL and pulls SDA low.
// Assumes the bench resolves SDA from every pull-down enable plus a pull-up.
`timescale 1ns/100ps
module rps_host_model #(
    parameter int Q = 8
) (
    // Clock
    input wire logic clk,
    // Bus
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    // Idle bus: SCL driven high, SDA released and held high by the pull-up, SCL stands still
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // Quarter bit waits; every change lands just after a clock edge
    task automatic qw(input int n);
        repeat (n * Q) @(posedge clk);
        #1;
    endtask

    // Data moves a quarter after SCL falls, so it never changes while SCL is high
    task automatic bitx(input logic b, output logic r);
        qw(1);
        sda_pull = ~b;
        qw(1);
        scl = 1'b1;
        qw(2);
        r = sda;
        scl = 1'b0;
    endtask

    // Start, or a repeated start when SCL is already low
    task automatic start();
        if (scl == 1'b0) begin
            qw(1);
            sda_pull = 1'b0;
            qw(1);
            scl = 1'b1;
        end
        qw(1);
        sda_pull = 1'b1;
        qw(1);
        scl = 1'b0;
    endtask

    task automatic stop();
        qw(1);
        sda_pull = 1'b1;
        qw(1);
        scl = 1'b1;
        qw(1);
        sda_pull = 1'b0;
        qw(1);
    endtask

    // Byte out MSB first; the slave acks by pulling SDA in the ninth slot
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask

    // Byte in; the last byte of a read is refused to end the message
    task automatic get(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(last, r);
    endtask

    // Address, 16-bit index, then n data bytes (0..2); ok when all were acked
    task automatic wr(input logic [7:0] adr, input logic [15:0] idx, input logic [7:0] d0,
                      input logic [7:0] d1, input int n, output logic ok);
        logic a;
        start();
        put(adr, ok);
        if (ok) begin
            put(idx[15:8], a);
            ok &= a;
            put(idx[7:0], a);
            ok &= a;
            if (n > 0) put(d0, a);
            if (n > 0) ok &= a;
            if (n > 1) put(d1, a);
            if (n > 1) ok &= a;
        end
        stop();
    endtask

    // Set the index, repeated start, read two bytes
    task automatic rd(input logic [15:0] idx, output logic [7:0] b0, output logic [7:0] b1);
        logic a;
        start();
        put(8'h52, a);
        put(idx[15:8], a);
        put(idx[7:0], a);
        start();
        put(8'h53, a);
        get(1'b0, b0);
        get(1'b1, b1);
        stop();
    endtask
endmodule

// ===== tb/rps_ctrl_tb.sv
// Self-checking bench for the power state controller and its serial slave.
// Assumes the host model above and pull-ups on SDA, event and spare pins.
`timescale 1ns/100ps
module rps_ctrl_tb;
    import rps_pkg::*;
    // ****************************************************************
    // Pins and wires
    // ****************************************************************
    logic core_clk, rst_n, i2c_reset, comms_en, scl, host_pull;
    logic sda_out, sda_oe, int_out, int_oe, spare_out, spare_oe, emit;
    logic [1:0] pstate;
    wire logic sda_wire, int_wire, spare_wire;
    int errors = 0;
    int cmp_count = 0;
    // Open-drain wires float high unless someone pulls
    assign sda_wire = (host_pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
    assign int_wire = (int_oe && !int_out) ? 1'b0 : 1'b1;
    assign spare_wire = (spare_oe && !spare_out) ? 1'b0 : 1'b1;

    rps_ctrl i_rps_ctrl (.CORE_CLK(core_clk), .RST_N(rst_n), .I2C_RESET(i2c_reset),
        .COMMS_ENABLE_LOW_POWER(comms_en), .SCL(scl), .SDA_IN(sda_wire),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .INT_IN(int_wire), .INT_OUT(int_out),
        .INT_OE(int_oe), .SPARE_GPIO_IN(spare_wire), .SPARE_GPIO_OUT(spare_out),
        .SPARE_GPIO_OE(spare_oe), .EMITTER_PULSE(emit), .POWER_STATE(pstate));
    rps_host_model i_rps_host_model (.clk(core_clk), .scl(scl), .sda_pull(host_pull),
        .sda(sda_wire));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Bounded wait for a power state; running out ends the run as a failure
    task automatic wait_state(input logic [1:0] s);
        int k;
        k = 0;
        while (pstate !== s && k < 200) begin
            cyc(1);
            k++;
        end
        if (k == 200) begin
            errors++;
            end_of_test();
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        logic ok;
        i_rps_host_model.wr(8'h52, CMD_IDX, c, 8'h00, 1, ok);
        check(ok, 16'h0001);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        check(pstate, P_AWAKE);
        check(emit, 16'h0000);
        check(int_oe, 16'h0000);
    endtask
    // Burst write then burst read, plus a foreign address
    task automatic t_write_read();
        logic ok;
        logic [7:0] b0, b1;
        i_rps_host_model.wr(8'h52, 16'h0010, 8'hA5, 8'h3C, 2, ok);
        check(ok, 16'h0001);
        i_rps_host_model.rd(16'h0010, b0, b1);
        check(b0, 16'h00A5);
        check(b1, 16'h003C);
        i_rps_host_model.wr(8'h54, 16'h0010, 8'h00, 8'h00, 1, ok);
        check(ok, 16'h0000);
    endtask
    task automatic t_ranging();
        logic prev;
        int n;
        logic [7:0] b0, b1;
        cmd(CMD_START);
        wait_state(P_RANGING);
        check(pstate, P_RANGING);
        prev = emit;
        n = 0;
        for (int i = 0; i < 10 * EMIT_CYCLES; i++) begin
            cyc(1);
            if (emit !== prev) n++;
            prev = emit;
        end
        check(n[15:0], 16'h000A);
        cmd(CMD_SLEEP);
        cyc(20);
        check(pstate, P_RANGING);
        cmd(CMD_STOP);
        wait_state(P_AWAKE);
        check(emit, 16'h0000);
        cyc(4 * EMIT_CYCLES);
        check(emit, 16'h0000);
        // Frames ended while ranging, so the event pin is pulled; a status read frees it
        check(int_oe, 16'h0001);
        i_rps_host_model.rd(STATUS_IDX, b0, b1);
        check(b0, 16'h0004);
        check(int_oe, 16'h0000);
        i_rps_host_model.rd(STATUS_IDX, b0, b1);
        check(b0, 16'h0000);
    endtask
    // Sleep with the bus gated, then ungated, then wake
    task automatic t_sleep();
        logic ok;
        logic [7:0] b0, b1;
        cmd(CMD_SLEEP);
        wait_state(P_SLEEP);
        check(pstate, P_SLEEP);
        comms_en = 1'b0;
        i_rps_host_model.wr(8'h52, 16'h0010, 8'h00, 8'h00, 1, ok);
        check(ok, 16'h0000);
        comms_en = 1'b1;
        cmd(CMD_START);
        cyc(20);
        check(pstate, P_SLEEP);
        check(emit, 16'h0000);
        i_rps_host_model.rd(16'h0010, b0, b1);
        check(b0, 16'h00A5);
        cmd(CMD_WAKE);
        wait_state(P_AWAKE);
        check(pstate, P_AWAKE);
        i_rps_host_model.rd(16'h0011, b0, b1);
        check(b0, 16'h003C);
    endtask
    // Bus reset pulse in mid-message while ranging
    task automatic t_bus_reset();
        logic a;
        logic [7:0] b0, b1;
        cmd(CMD_START);
        wait_state(P_RANGING);
        i_rps_host_model.start();
        i_rps_host_model.put(8'h52, a);
        i_rps_host_model.put(8'h00, a);
        i2c_reset = 1'b1;
        cyc(10);
        check(sda_oe, 16'h0000);
        i2c_reset = 1'b0;
        cyc(10);
        // A slave still mid-message would ack this index byte
        i_rps_host_model.put(8'h10, a);
        check(a, 16'h0000);
        i_rps_host_model.stop();
        check(pstate, P_RANGING);
        i_rps_host_model.rd(16'h0010, b0, b1);
        check(b0, 16'h00A5);
        cmd(CMD_STOP);
        wait_state(P_AWAKE);
    endtask

    // ****************************************************************
    // Clock, monitors and main sequence
    // ****************************************************************
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Open-drain pins must never drive high
    always @(negedge core_clk) begin
        if (rst_n === 1'b1) begin
            check(sda_out, 16'h0000);
            check(int_out, 16'h0000);
            check({spare_oe, spare_out}, 16'h0000);
        end
    end
    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge core_clk);
        errors++;
        end_of_test();
    end
    initial begin
        rst_n = 1'b0;
        i2c_reset = 1'b0;
        comms_en = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        cyc(6);
        t_reset();
        t_write_read();
        t_ranging();
        t_sleep();
        t_bus_reset();
        end_of_test();
    end
endmodule
